// [inc/gss_pkg.sv]
`default_nettype none
package gss_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_PREHEAT,
		ST_CRANK,
		ST_REST,
		ST_BYPASS,
		ST_RUN,
		ST_RUN_ON,
		ST_COOL,
		ST_FAULT
	} gss_state_e;

	// One timer tick is one millisecond of the 50 MHz system clock.
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

	// Alarm bit positions.
	localparam int AL_LOP = 0;
	localparam int AL_HTEMP = 1;
	localparam int AL_OVSPD = 2;
	localparam int AL_UNDER = 3;
	localparam int AL_NOSPD = 4;
	localparam int AL_OVCRANK = 5;
	localparam int AL_W = 6;

	// Configuration selectors for the load port.
	localparam logic [3:0] CFG_QUAL = 4'h0;
	localparam logic [3:0] CFG_PREHEAT = 4'h1;
	localparam logic [3:0] CFG_CRANK = 4'h2;
	localparam logic [3:0] CFG_REST = 4'h3;
	localparam logic [3:0] CFG_BYPASS = 4'h4;
	localparam logic [3:0] CFG_RUN_ON = 4'h5;
	localparam logic [3:0] CFG_COOL = 4'h6;
	localparam logic [3:0] CFG_WIN = 4'h7;
	localparam logic [3:0] CFG_LOSS = 4'h8;
	localparam logic [3:0] CFG_CYCLES = 4'h9;
	localparam logic [3:0] CFG_PH_EN = 4'ha;
	localparam logic [3:0] CFG_PH_TEMP = 4'hb;
	localparam logic [3:0] CFG_HI_TEMP = 4'hc;
	localparam logic [3:0] CFG_CUT = 4'hd;
	localparam logic [3:0] CFG_OVER = 4'he;
	localparam logic [3:0] CFG_UNDER = 4'hf;

	// Factory defaults; periods in milliseconds, speeds in pulses per window.
	localparam logic [15:0] DEF_QUAL = 16'h1388;
	localparam logic [15:0] DEF_PREHEAT = 16'h2710;
	localparam logic [15:0] DEF_CRANK = 16'h1388;
	localparam logic [15:0] DEF_REST = 16'h2710;
	localparam logic [15:0] DEF_BYPASS = 16'h2710;
	localparam logic [15:0] DEF_RUN_ON = 16'hea60;
	localparam logic [15:0] DEF_COOL = 16'hea60;
	localparam logic [15:0] DEF_WIN = 16'h0064;
	localparam logic [15:0] DEF_LOSS = 16'h07d0;
	localparam logic [3:0] DEF_CYCLES = 4'h3;
	localparam logic DEF_PH_EN = 1'b1;
	localparam logic [7:0] DEF_PH_TEMP = 8'h0a;
	localparam logic [7:0] DEF_HI_TEMP = 8'h82;
	localparam logic [7:0] DEF_CUT = 8'h0a;
	localparam logic [7:0] DEF_OVER = 8'h28;
	localparam logic [7:0] DEF_UNDER = 8'h14;
	// Output current limit in amps and the cooldown field duty.
	localparam logic [7:0] CUR_LIMIT = 8'h37;
	localparam logic [7:0] DUTY_MIN = 8'h10;
	localparam logic [7:0] DUTY_MAX = 8'hff;

endpackage
`default_nettype wire

// [hw/gss_generator_system.sv]
// Function
// - Start only after request persists qualify delay.
// - Preheat below set temperature before cranking.
// - Crank until started or crank limit.
// - Rest between failed crank attempts.
// - Stop after cycle count, flag overcrank.
// - Arm oil and underspeed after bypass.
// - Shutdown only when all requests removed.
// - Request during shutdown returns to running.
// - Run-on timer after last request drops.
// - Cooldown at minimal output, then stop.
// - Cooldown needs qualified request to resume.
// - Start relay only while cranking.
// - Fuel hold relay while engine runs.
// - Speed ends cranking, detects over/underspeed.
// - Missing speed signal faults the engine.
// - High oil temperature shuts down, flags.
// - Regulate output current to 55 A.
// - Low oil pressure after bypass stops engine.
// - Alarms latch until explicitly cleared.
`timescale 1ns/1ps
`default_nettype none
module gss_generator_system
	import gss_pkg::*;
#(
	parameter int N_REQ = 4,
	parameter int TICK_CYC = TICK_CYCLES
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [N_REQ-1:0] start_req,
	input wire logic speed_pulse,
	input wire logic low_oil_sw,
	input wire logic [7:0] oil_temp,
	input wire logic [7:0] out_current,
	input wire logic cfg_load,
	input wire logic [3:0] cfg_sel,
	input wire logic [15:0] cfg_data,
	input wire logic alarm_clear,
	output logic start_relay,
	output logic fuel_relay,
	output logic preheat_relay,
	output logic cooldown_mode,
	output logic [7:0] field_duty,
	output logic [AL_W-1:0] alarms,
	output logic [7:0] engine_speed,
	output logic [3:0] run_state
);

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
	typedef struct packed {
		gss_state_e st;
		logic [2:0][N_REQ-1:0] req_s;
		logic [N_REQ-1:0] req_f;
		logic [2:0] spd_s;
		logic spd_f;
		logic [2:0] lop_s;
		logic lop_f;
		logic [15:0] ms_div;
		logic [15:0] tmr;
		logic [15:0] qual;
		logic [15:0] win;
		logic [15:0] quiet;
		logic [3:0] cycles;
		logic [7:0] pulses;
		logic [7:0] speed;
		logic [AL_W-1:0] al;
		logic [15:0] c_qual;
		logic [15:0] c_ph;
		logic [15:0] c_crank;
		logic [15:0] c_rest;
		logic [15:0] c_byp;
		logic [15:0] c_runon;
		logic [15:0] c_cool;
		logic [15:0] c_win;
		logic [15:0] c_loss;
		logic [3:0] c_cycles;
		logic c_ph_en;
		logic [7:0] c_ph_temp;
		logic [7:0] c_hi_temp;
		logic [7:0] c_cut;
		logic [7:0] c_over;
		logic [7:0] c_under;
		logic start;
		logic fuel;
		logic pre;
		logic cool;
		logic [7:0] duty;
	} gss_regs_s;
	gss_regs_s r;
	gss_regs_s n;
	logic tick;
	logic any_req;
	logic qualified;
	logic rise;
	logic running;
	logic armed;
	logic [AL_W-1:0] f;
	function automatic logic [15:0] inc16(input logic [15:0] v);
		inc16 = (v == 16'hffff) ? v : v + 16'h0001;
	endfunction
	always_comb
	begin
		n = r;
		f = '0;
		tick = (r.ms_div == TICK_LAST);
		any_req = |r.req_f;
		qualified = any_req && (r.qual >= r.c_qual);
		running = r.st inside {ST_BYPASS, ST_RUN, ST_RUN_ON, ST_COOL};
		// Oil pressure and underspeed stay blind during the bypass period.
		armed = r.st inside {ST_RUN, ST_RUN_ON, ST_COOL};
		// Pin inputs: a change counts once the second and third stages agree.
		n.req_s = {r.req_s[1], r.req_s[0], start_req};
		n.req_f = (r.req_s[1] & r.req_s[2])
			| (r.req_f & (r.req_s[1] | r.req_s[2]));
		n.spd_s = {r.spd_s[1:0], speed_pulse};
		n.spd_f = (r.spd_s[1] & r.spd_s[2])
			| (r.spd_f & (r.spd_s[1] | r.spd_s[2]));
		n.lop_s = {r.lop_s[1:0], low_oil_sw};
		n.lop_f = (r.lop_s[1] & r.lop_s[2])
			| (r.lop_f & (r.lop_s[1] | r.lop_s[2]));
		rise = n.spd_f & ~r.spd_f;
		n.ms_div = tick ? '0 : r.ms_div + 16'h0001;
		n.tmr = tick ? inc16(r.tmr) : r.tmr;
		// A request must persist unbroken for the qualify delay.
		if (!any_req)
			n.qual = '0;
		else if (tick)
			n.qual = inc16(r.qual);
		// Speed is the pulse count over one measuring window.
		n.quiet = rise ? '0 : (tick ? inc16(r.quiet) : r.quiet);
		if (rise && r.pulses != 8'hff)
			n.pulses = r.pulses + 8'h01;
		if (tick)
		begin
			if (r.win >= r.c_win - 16'h0001)
			begin
				n.win = '0;
				n.speed = r.pulses;
				n.pulses = {7'h00, rise};
			end
			else
				n.win = r.win + 16'h0001;
		end
		f[AL_HTEMP] = running && (oil_temp > r.c_hi_temp);
		f[AL_OVSPD] = running && (r.speed > r.c_over);
		f[AL_NOSPD] = running && (r.quiet >= r.c_loss);
		f[AL_LOP] = armed && r.lop_f;
		f[AL_UNDER] = armed && (r.speed < r.c_under);
		case (r.st)
			ST_IDLE:
			begin
				n.cycles = '0;
				if (qualified)
				begin
					if (r.c_ph_en && oil_temp < r.c_ph_temp)
						n.st = ST_PREHEAT;
					else
						n.st = ST_CRANK;
				end
			end
			ST_PREHEAT:
				if (r.tmr >= r.c_ph)
					n.st = ST_CRANK;
			ST_CRANK:
				if (r.speed >= r.c_cut)
					n.st = ST_BYPASS;
				else if (r.tmr >= r.c_crank)
				begin
					n.cycles = r.cycles + 4'h1;
					if ({1'b0, r.cycles} + 5'h01 >= {1'b0, r.c_cycles})
					begin
						f[AL_OVCRANK] = 1'b1;
						n.st = ST_FAULT;
					end
					else
						n.st = ST_REST;
				end
			ST_REST:
				if (r.tmr >= r.c_rest)
					n.st = ST_CRANK;
			ST_BYPASS:
				if (r.tmr >= r.c_byp)
					n.st = ST_RUN;
			ST_RUN:
				if (!any_req)
					n.st = ST_RUN_ON;
			ST_RUN_ON:
				if (any_req)
					n.st = ST_RUN;
				else if (r.tmr >= r.c_runon)
					n.st = ST_COOL;
			ST_COOL:
				if (qualified)
					n.st = ST_RUN;
				else if (r.tmr >= r.c_cool)
					n.st = ST_IDLE;
			ST_FAULT:
				if (alarm_clear)
					n.st = ST_IDLE;
			default:
				n.st = ST_IDLE;
		endcase
		if (|f)
			n.st = ST_FAULT;
		// A new fault wins over a clear in the same cycle.
		n.al = (alarm_clear ? '0 : r.al) | f;
		if (n.st != r.st)
			n.tmr = '0;
		n.start = (n.st == ST_CRANK);
		n.fuel = n.st inside {ST_CRANK, ST_BYPASS, ST_RUN,
			ST_RUN_ON, ST_COOL};
		n.pre = (n.st == ST_PREHEAT);
		n.cool = (n.st == ST_COOL);
		// Field duty steps one count per tick toward the current limit in bypass, run and run-on.
		if (!(n.st inside {ST_BYPASS, ST_RUN, ST_RUN_ON, ST_COOL}))
			n.duty = '0;
		else if (n.st == ST_COOL)
			n.duty = DUTY_MIN;
		else if (tick)
		begin
			if (out_current > CUR_LIMIT && r.duty != 8'h00)
				n.duty = r.duty - 8'h01;
			else if (out_current < CUR_LIMIT && r.duty != DUTY_MAX)
				n.duty = r.duty + 8'h01;
		end
		if (cfg_load)
		begin
			case (cfg_sel)
				CFG_QUAL: n.c_qual = cfg_data;
				CFG_PREHEAT: n.c_ph = cfg_data;
				CFG_CRANK: n.c_crank = cfg_data;
				CFG_REST: n.c_rest = cfg_data;
				CFG_BYPASS: n.c_byp = cfg_data;
				CFG_RUN_ON: n.c_runon = cfg_data;
				CFG_COOL: n.c_cool = cfg_data;
				CFG_WIN: n.c_win = cfg_data;
				CFG_LOSS: n.c_loss = cfg_data;
				CFG_CYCLES: n.c_cycles = cfg_data[3:0];
				CFG_PH_EN: n.c_ph_en = cfg_data[0];
				CFG_PH_TEMP: n.c_ph_temp = cfg_data[7:0];
				CFG_HI_TEMP: n.c_hi_temp = cfg_data[7:0];
				CFG_CUT: n.c_cut = cfg_data[7:0];
				CFG_OVER: n.c_over = cfg_data[7:0];
				default: n.c_under = cfg_data[7:0];
			endcase
		end
		if (!rst_b)
		begin
			n = '0;
			n.st = ST_IDLE;
			n.c_qual = DEF_QUAL;
			n.c_ph = DEF_PREHEAT;
			n.c_crank = DEF_CRANK;
			n.c_rest = DEF_REST;
			n.c_byp = DEF_BYPASS;
			n.c_runon = DEF_RUN_ON;
			n.c_cool = DEF_COOL;
			n.c_win = DEF_WIN;
			n.c_loss = DEF_LOSS;
			n.c_cycles = DEF_CYCLES;
			n.c_ph_en = DEF_PH_EN;
			n.c_ph_temp = DEF_PH_TEMP;
			n.c_hi_temp = DEF_HI_TEMP;
			n.c_cut = DEF_CUT;
			n.c_over = DEF_OVER;
			n.c_under = DEF_UNDER;
		end
	end
	always_ff @(posedge clock)
		r <= n;
	assign start_relay = r.start;
	assign fuel_relay = r.fuel;
	assign preheat_relay = r.pre;
	assign cooldown_mode = r.cool;
	assign field_duty = r.duty;
	assign alarms = r.al;
	assign engine_speed = r.speed;
	assign run_state = r.st;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	AST_QUALIFY: assert property (
		(r.st == ST_IDLE && n.st inside {ST_PREHEAT, ST_CRANK})
			|-> (r.qual >= r.c_qual) && any_req)
		else $error("start taken before qualification");
	AST_PREHEAT: assert property (
		$rose(preheat_relay) |-> $past(r.c_ph_en)
			&& $past(oil_temp) < $past(r.c_ph_temp))
		else $error("preheat without enable or cold engine");
	AST_CRANK_LIMIT: assert property (
		(r.st == ST_CRANK && r.tmr >= r.c_crank && r.speed < r.c_cut)
			|=> !start_relay)
		else $error("cranking past crank limit");
	AST_REST: assert property (
		(r.st == ST_REST ##1 r.st == ST_CRANK)
			|-> $past(r.tmr) >= $past(r.c_rest))
		else $error("rest period cut short");
	AST_OVERCRANK: assert property (
		$rose(alarms[AL_OVCRANK]) |-> $past(r.st) == ST_CRANK
			&& {1'b0, $past(r.cycles)} + 5'h01
			>= {1'b0, $past(r.c_cycles)})
		else $error("overcrank at wrong cycle count");
	AST_BYPASS_MASK: assert property (
		$rose(alarms[AL_LOP]) || $rose(alarms[AL_UNDER])
			|-> $past(r.st) inside {ST_RUN, ST_RUN_ON, ST_COOL})
		else $error("oil or underspeed alarm during bypass");
	AST_HOLD_RUN: assert property (
		(r.st == ST_RUN && any_req) |=> r.st inside {ST_RUN, ST_FAULT})
		else $error("shutdown begun with a request active");
	AST_RETURN: assert property (
		(r.st == ST_RUN_ON && any_req)
			|=> r.st inside {ST_RUN, ST_FAULT})
		else $error("request in run-on did not return to running");
	AST_COOL_DUTY: assert property (
		cooldown_mode |-> field_duty == DUTY_MIN && fuel_relay)
		else $error("cooldown without minimal output");
	AST_START_RELAY: assert property (
		start_relay |-> r.st == ST_CRANK && fuel_relay)
		else $error("start relay outside cranking");
	AST_LATCH: assert property (
		(alarms != '0 && !alarm_clear) |=> alarms != '0)
		else $error("alarm dropped without clear");
	AST_FAULT_OFF: assert property (
		$rose(alarms[AL_HTEMP]) |-> !fuel_relay && r.st == ST_FAULT)
		else $error("high temperature did not stop engine");

	COV_START: cover property (r.st == ST_CRANK ##1 r.st == ST_BYPASS);
	COV_SHUTDOWN: cover property (r.st == ST_COOL ##1 r.st == ST_IDLE);
	COV_RESUME: cover property (r.st == ST_COOL ##1 r.st == ST_RUN);
	COV_OVERCRANK: cover property ($rose(alarms[AL_OVCRANK]));

endmodule
`default_nettype wire

// [test/gss_engine_model.sv]
`timescale 1ns/1ps
`default_nettype none
module gss_engine_model
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic start_relay,
	input wire logic fuel_relay,
	input wire logic will_start,
	input wire logic cold,
	input wire logic [1:0] fault,
	output logic speed_pulse,
	output logic low_oil_sw,
	output logic [7:0] oil_temp,
	output logic [7:0] out_current
);
	logic running;
	logic [1:0] phase;

	// The engine fires while cranked with fuel and stops once fuel is cut.
	always_ff @(posedge clock)
	begin
		if (!rst_b || !fuel_relay)
			running <= 1'b0;
		else if (start_relay && will_start)
			running <= 1'b1;
		phase <= rst_b ? phase + 2'b01 : 2'b00;
	end

	// The speed line stands still while the engine is stopped.
	// Each pulse lasts two clocks so that the pin filter can see it.
	assign speed_pulse = running & phase[1];
	assign low_oil_sw = fault[0];
	assign oil_temp = fault[1] ? 8'hc8 : (cold ? 8'h05 : 8'h32);
	assign out_current = running ? 8'h30 : 8'h00;
endmodule
`default_nettype wire

// [test/gss_generator_system_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module gss_generator_system_tb_top
	import gss_pkg::*;
;
	logic clock, rst_b, cfg_load, alarm_clear, will_start, cold;
	logic speed_pulse, low_oil_sw, start_relay, fuel_relay;
	logic preheat_relay, cooldown_mode;
	logic [1:0] fault;
	logic [3:0] start_req, cfg_sel, run_state;
	logic [15:0] cfg_data;
	logic [7:0] oil_temp, out_current, field_duty, engine_speed;
	logic [AL_W-1:0] alarms;
	int error_cnt = 0;
	int n_tests = 0;

	gss_generator_system #(.N_REQ(4), .TICK_CYC(10)) dut (
		.clock(clock), .rst_b(rst_b), .start_req(start_req),
		.speed_pulse(speed_pulse), .low_oil_sw(low_oil_sw),
		.oil_temp(oil_temp), .out_current(out_current),
		.cfg_load(cfg_load), .cfg_sel(cfg_sel), .cfg_data(cfg_data),
		.alarm_clear(alarm_clear), .start_relay(start_relay),
		.fuel_relay(fuel_relay), .preheat_relay(preheat_relay),
		.cooldown_mode(cooldown_mode), .field_duty(field_duty),
		.alarms(alarms), .engine_speed(engine_speed),
		.run_state(run_state));

	gss_engine_model eng (
		.clock(clock), .rst_b(rst_b), .start_relay(start_relay),
		.fuel_relay(fuel_relay), .will_start(will_start), .cold(cold),
		.fault(fault), .speed_pulse(speed_pulse),
		.low_oil_sw(low_oil_sw), .oil_temp(oil_temp),
		.out_current(out_current));

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic results();
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: exp %h got %h", $time, exp, got);
		end
	endtask

	task automatic wait_st(input gss_state_e s, input int lim);
		int i;
		i = 0;
		while (run_state !== s && i < lim)
		begin
			@(negedge clock);
			i++;
		end
		chk({4'h0, s}, {4'h0, run_state});
		if (run_state !== s)
			results();
	endtask

	task automatic set(input logic [3:0] sel, input logic [15:0] val);
		cfg_sel = sel;
		cfg_data = val;
		cfg_load = 1'b1;
		@(negedge clock);
		cfg_load = 1'b0;
		@(negedge clock);
	endtask

	task automatic short_req();
		start_req = 4'h2;
		repeat (15) @(negedge clock);
		start_req = 4'h0;
		repeat (60) @(negedge clock);
		chk({4'h0, ST_IDLE}, {4'h0, run_state});
	endtask

	task automatic start_eng(input logic c);
		logic [7:0] d;
		// Let the speed window of an earlier run drain to zero.
		repeat (60) @(negedge clock);
		cold = c;
		will_start = 1'b1;
		start_req = 4'h1;
		if (c)
		begin
			wait_st(ST_PREHEAT, 200);
			chk(8'h01, {7'h00, preheat_relay});
		end
		wait_st(ST_CRANK, 200);
		chk(8'h03, {6'h00, start_relay, fuel_relay});
		wait_st(ST_BYPASS, 200);
		chk(8'h01, {6'h00, start_relay, fuel_relay});
		wait_st(ST_RUN, 200);
		chk(8'h05, engine_speed);
		d = field_duty;
		repeat (10) @(negedge clock);
		chk(d + 8'h01, field_duty);
	endtask

	task automatic shutdown();
		start_req = 4'h0;
		wait_st(ST_RUN_ON, 20);
		start_req = 4'h8;
		wait_st(ST_RUN, 20);
		start_req = 4'h0;
		wait_st(ST_RUN_ON, 20);
		repeat (30) @(negedge clock);
		chk({4'h0, ST_RUN_ON}, {4'h0, run_state});
		wait_st(ST_COOL, 200);
		chk(8'h03, {6'h00, cooldown_mode, fuel_relay});
		chk(DUTY_MIN, field_duty);
		start_req = 4'h4;
		wait_st(ST_RUN, 60);
		start_req = 4'h0;
		wait_st(ST_RUN_ON, 20);
		wait_st(ST_COOL, 200);
		start_req = 4'h4;
		repeat (8) @(negedge clock);
		start_req = 4'h0;
		repeat (6) @(negedge clock);
		chk({4'h0, ST_COOL}, {4'h0, run_state});
		wait_st(ST_IDLE, 200);
		chk(8'h00, {7'h00, fuel_relay});
	endtask

	task automatic clear_alarm(input logic [7:0] exp);
		chk(8'h00, {7'h00, fuel_relay});
		start_req = 4'h0;
		repeat (5) @(negedge clock);
		chk(exp, {2'b00, alarms});
		alarm_clear = 1'b1;
		@(negedge clock);
		alarm_clear = 1'b0;
		wait_st(ST_IDLE, 10);
		chk(8'h00, {2'b00, alarms});
	endtask

	task automatic overcrank();
		repeat (60) @(negedge clock);
		will_start = 1'b0;
		cold = 1'b0;
		start_req = 4'h1;
		wait_st(ST_REST, 400);
		chk(8'h00, {7'h00, start_relay});
		wait_st(ST_CRANK, 100);
		wait_st(ST_FAULT, 400);
		clear_alarm(8'h20);
	endtask

	task automatic cfg_fault(input logic [3:0] sel, input logic [15:0] bad,
		input logic [15:0] good, input logic [7:0] exp);
		start_eng(1'b0);
		set(sel, bad);
		wait_st(ST_FAULT, 20);
		clear_alarm(exp);
		set(sel, good);
	endtask

	task automatic faults();
		for (int k = 0; k < 2; k++)
		begin
			start_eng(1'b0);
			fault = 2'(k + 1);
			wait_st(ST_FAULT, 20);
			fault = 2'b00;
			clear_alarm(8'(k + 1));
		end
		cfg_fault(CFG_UNDER, 16'h0006, 16'h0003, 8'h08);
		cfg_fault(CFG_OVER, 16'h0004, {8'h00, DEF_OVER}, 8'h04);
		cfg_fault(CFG_LOSS, 16'h0000, DEF_LOSS, 8'h10);
	endtask

	initial
	begin
		rst_b = 1'b0;
		start_req = 4'h0;
		cfg_load = 1'b0;
		cfg_sel = 4'h0;
		cfg_data = 16'h0000;
		alarm_clear = 1'b0;
		will_start = 1'b0;
		cold = 1'b0;
		fault = 2'b00;
		repeat (16) @(negedge clock);
		rst_b = 1'b1;
		@(negedge clock);
		chk(8'h00, {4'h0, run_state});
		set(CFG_QUAL, 16'h0003);
		set(CFG_PREHEAT, 16'h0003);
		set(CFG_CRANK, 16'h0008);
		set(CFG_REST, 16'h0003);
		set(CFG_BYPASS, 16'h0005);
		set(CFG_RUN_ON, 16'h0005);
		set(CFG_COOL, 16'h0005);
		set(CFG_WIN, 16'h0002);
		set(CFG_CYCLES, 16'h0002);
		set(CFG_CUT, 16'h0004);
		set(CFG_UNDER, 16'h0003);
		short_req();
		start_eng(1'b1);
		shutdown();
		overcrank();
		faults();
		results();
	end
endmodule
`default_nettype wire
